// >>> src/bdio_ports.sv
// Three bidirectional parallel ports with direction and output latches
//
// Notes on behaviour
// RULE_01 - Twenty lines: two eight-bit, one four-bit port
// RULE_02 - Direction bit one drives, zero listens
// RULE_03 - Direction registers are write-only, read all ones
// RULE_04 - Reset clears every direction bit to input
// RULE_05 - Reset leaves output latches untouched
// RULE_06 - Output line reads back its latch
// RULE_07 - Port write updates every latch bit
// RULE_08 - Input line reads the pin level
// RULE_09 - Input lines float; port one may pull up
// RULE_10 - Pin levels pass a synchroniser before reads
`timescale 1ns/1ns
`include "bdio_map.svh"

module bdio_ports #(
  parameter int PORT_ONE_W   = 8,
  parameter int PORT_TWO_W   = 8,
  parameter int PORT_THREE_W = 4,
  parameter bit PULLUP_EN    = 1'b0
) (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic [`BDIO_ADDR_W-1:0]       cpu_addr,
  input  wire logic                          cpu_wr,
  input  wire logic                          cpu_rd,
  input  wire logic [7:0]                    cpu_wdata,
  output logic      [7:0]                    cpu_rdata_q,
  output logic                               cpu_rvalid_q,
  input  wire logic [PORT_ONE_W-1:0]         port_one_lines_in,
  output logic      [PORT_ONE_W-1:0]         port_one_lines_out_q,
  output logic      [PORT_ONE_W-1:0]         port_one_lines_oe_q,
  output logic      [PORT_ONE_W-1:0]         port_one_pullup_q,
  input  wire logic [PORT_TWO_W-1:0]         port_two_lines_in,
  output logic      [PORT_TWO_W-1:0]         port_two_lines_out_q,
  output logic      [PORT_TWO_W-1:0]         port_two_lines_oe_q,
  input  wire logic [PORT_THREE_W-1:0]       port_three_lines_in,
  output logic      [PORT_THREE_W-1:0]       port_three_lines_out_q,
  output logic      [PORT_THREE_W-1:0]       port_three_lines_oe_q
);

  // ----------------------------------------------------------------------
  // Elaboration checks: the datapath is one byte wide per port
  // ----------------------------------------------------------------------
  if (PORT_ONE_W < 1 || PORT_ONE_W > 8 || PORT_TWO_W < 1 || PORT_TWO_W > 8 ||
      PORT_THREE_W < 1 || PORT_THREE_W > 8) begin : g_bad_width
    $error("bdio_ports: port widths must lie in 1..8");
  end

  // ----------------------------------------------------------------------
  // Decode helpers, shared by write, read and pull-up logic
  // ----------------------------------------------------------------------
  function automatic bdio_pkg::bdio_target_t target_of(input logic [`BDIO_ADDR_W-1:0] a);
    if (a[1:0] == 2'h3) begin
      target_of = bdio_pkg::BDIO_T_NONE;
    end else if (a[`BDIO_DIR_SEL_BIT]) begin
      target_of = bdio_pkg::BDIO_T_DIR;
    end else begin
      target_of = bdio_pkg::BDIO_T_DATA;
    end
  endfunction

  function automatic logic [7:0] mask_of(input logic [1:0] idx);
    int w;
    w = (idx == 2'h0) ? PORT_ONE_W : (idx == 2'h1) ? PORT_TWO_W : PORT_THREE_W;
    mask_of = 8'((9'h001 << w) - 9'h001);
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  bdio_pkg::bdio_byte_t dir_q [3];
  bdio_pkg::bdio_byte_t dir_d [3];
  bdio_pkg::bdio_byte_t lat_q [3];
  bdio_pkg::bdio_byte_t lat_d [3];
  bdio_pkg::bdio_byte_t pin_raw [3];
  bdio_pkg::bdio_byte_t pin_s [3];
  bdio_pkg::bdio_byte_t rdata_d;
  logic                 rvalid_d;
  logic [7:0]           pull_d;
  logic [7:0]           pull_q;
  logic [1:0]           acc_idx;

  assign acc_idx = cpu_addr[1:0];

  // ----------------------------------------------------------------------
  // Pin sampling: one synchroniser per port, zero-extended to a byte
  // ----------------------------------------------------------------------
  assign pin_raw[0] = 8'(port_one_lines_in);
  assign pin_raw[1] = 8'(port_two_lines_in);
  assign pin_raw[2] = 8'(port_three_lines_in);

  for (genvar g = 0; g < 3; g++) begin : g_sync // RULE_01
    bdio_sync #(
      .W (8)
    ) u_sync (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .pin_raw    (pin_raw[g]),
      .pin_sync_q (pin_s[g])
    ); // RULE_10
  end

  // ----------------------------------------------------------------------
  // Direction and latch next state
  // ----------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      dir_d[i] = dir_q[i];
      lat_d[i] = lat_q[i];
    end
    if (cpu_wr && !sys_rst) begin
      unique case (target_of(cpu_addr))
        bdio_pkg::BDIO_T_DIR: begin
          dir_d[acc_idx] = cpu_wdata & mask_of(acc_idx); // RULE_02
        end
        bdio_pkg::BDIO_T_DATA: begin
          // Whole port written, whatever the direction bits say
          lat_d[acc_idx] = cpu_wdata & mask_of(acc_idx); // RULE_07
        end
        bdio_pkg::BDIO_T_NONE: begin
        end
      endcase
    end
    // Pull-up sits only on input lines of port one, when fitted
    pull_d = PULLUP_EN ? (~dir_d[0] & mask_of(2'h0)) : 8'h00; // RULE_09
    if (sys_rst) begin
      pull_d = PULLUP_EN ? mask_of(2'h0) : 8'h00;
    end
  end

  // Direction resets to input; latches deliberately carry no reset
  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (sys_rst) begin
        dir_q[i] <= `BDIO_DIR_RST; // RULE_04
      end else begin
        dir_q[i] <= dir_d[i];
      end
      lat_q[i] <= lat_d[i]; // RULE_05
    end
    pull_q <= pull_d;
  end

  // ----------------------------------------------------------------------
  // Read path: one cycle after the strobe, reads see pre-write state
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_d  = cpu_rdata_q;
    rvalid_d = cpu_rd;
    if (cpu_rd) begin
      unique case (target_of(cpu_addr))
        bdio_pkg::BDIO_T_DIR: begin
          rdata_d = `BDIO_DIR_READ; // RULE_03
        end
        bdio_pkg::BDIO_T_DATA: begin
          // Output lines give the latch, input lines the synced pin
          rdata_d = ((dir_q[acc_idx] & lat_q[acc_idx]) | // RULE_06
                     (~dir_q[acc_idx] & pin_s[acc_idx])) // RULE_08
                    & mask_of(acc_idx);
        end
        bdio_pkg::BDIO_T_NONE: begin
          rdata_d = `BDIO_UNMAPPED_READ;
        end
      endcase
    end
  end

  // Read data holds until the next read or a reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpu_rdata_q  <= `BDIO_RDATA_RST;
      cpu_rvalid_q <= 1'b0;
    end else begin
      cpu_rdata_q  <= rdata_d;
      cpu_rvalid_q <= rvalid_d;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers: enable is the direction bit, so inputs float
  // ----------------------------------------------------------------------
  assign port_one_lines_out_q   = lat_q[0][PORT_ONE_W-1:0];
  assign port_one_lines_oe_q    = dir_q[0][PORT_ONE_W-1:0]; // RULE_09
  assign port_one_pullup_q      = pull_q[PORT_ONE_W-1:0];
  assign port_two_lines_out_q   = lat_q[1][PORT_TWO_W-1:0];
  assign port_two_lines_oe_q    = dir_q[1][PORT_TWO_W-1:0];
  assign port_three_lines_out_q = lat_q[2][PORT_THREE_W-1:0];
  assign port_three_lines_oe_q  = dir_q[2][PORT_THREE_W-1:0];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_dir_read_ones: assert property ( // RULE_03
    cpu_rd && cpu_addr[`BDIO_DIR_SEL_BIT] && cpu_addr[1:0] != 2'h3
      |=> cpu_rvalid_q && cpu_rdata_q == 8'hFF)
    else $error("direction register read did not return all ones");

  a_reset_inputs: assert property (disable iff (1'b0) // RULE_04
    sys_rst |=> port_one_lines_oe_q == '0 && port_two_lines_oe_q == '0
                && port_three_lines_oe_q == '0)
    else $error("reset did not turn every line into an input");

  // Armed only by a reset in mid-run; the power-up reset meets latches still unknown
  a_reset_keeps_latch: assert property (disable iff (1'b0) // RULE_05
    !sys_rst ##1 sys_rst |=> port_two_lines_out_q == $past(port_two_lines_out_q))
    else $error("reset disturbed an output latch");

  a_out_reads_latch: assert property ( // RULE_06
    cpu_rd && cpu_addr == `BDIO_OFF_DATA2 && !cpu_wr
      |=> (cpu_rdata_q & dir_q[1]) == (lat_q[1] & dir_q[1]))
    else $error("output line read did not return its latch");

  a_in_reads_pin: assert property ( // RULE_08
    cpu_rd && cpu_addr == `BDIO_OFF_DATA1
      |=> (cpu_rdata_q & ~$past(dir_q[0])) == ($past(pin_s[0]) & ~$past(dir_q[0])))
    else $error("input line read did not return the pin level");

  a_write_all_bits: assert property ( // RULE_07
    cpu_wr && cpu_addr == `BDIO_OFF_DATA2 |=> lat_q[1] == $past(cpu_wdata))
    else $error("port write did not update every latch bit");

  a_dir_sets_drive: assert property ( // RULE_02
    cpu_wr && cpu_addr == `BDIO_OFF_DIR3
      |=> port_three_lines_oe_q == $past(cpu_wdata[PORT_THREE_W-1:0])
          ##1 $stable(port_three_lines_oe_q) || $past(cpu_wr))
    else $error("direction write did not steer the line drivers");

  a_pullup_inputs: assert property ( // RULE_09
    (port_one_pullup_q & port_one_lines_oe_q) == '0)
    else $error("pull-up active on a driven line");

  c_dir_write: cover property (cpu_wr && cpu_addr == `BDIO_OFF_DIR1);
  c_mixed_read: cover property (
    cpu_rd && cpu_addr == `BDIO_OFF_DATA1 && dir_q[0] != 8'h00 && dir_q[0] != 8'hFF);
  c_dir_read: cover property (cpu_rd && cpu_addr == `BDIO_OFF_DIR2);
  c_write_then_read: cover property (
    cpu_wr && cpu_addr == `BDIO_OFF_DATA3 ##1 cpu_rd && cpu_addr == `BDIO_OFF_DATA3);

endmodule

// >>> src/bdio_map.svh
// Address map, reset values and constants of the bidirectional port block
`ifndef BDIO_MAP_SVH
`define BDIO_MAP_SVH

// ----------------------------------------------------------------------
// Access port layout
// ----------------------------------------------------------------------
`define BDIO_ADDR_W        3
`define BDIO_OFF_DATA1     3'h0
`define BDIO_OFF_DATA2     3'h1
`define BDIO_OFF_DATA3     3'h2
`define BDIO_OFF_DIR1      3'h4
`define BDIO_OFF_DIR2      3'h5
`define BDIO_OFF_DIR3      3'h6
`define BDIO_DIR_SEL_BIT   2

// ----------------------------------------------------------------------
// Reset and read-back values
// ----------------------------------------------------------------------
`define BDIO_DIR_RST       8'h00
`define BDIO_DIR_READ      8'hFF
`define BDIO_UNMAPPED_READ 8'h00
`define BDIO_RDATA_RST     8'h00
`define BDIO_SYNC_RST      8'h00

`endif

// >>> src/bdio_pkg.sv
// Types shared by the bidirectional port block
package bdio_pkg;

  // ----------------------------------------------------------------------
  // Access decode result
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    BDIO_T_NONE,
    BDIO_T_DATA,
    BDIO_T_DIR
  } bdio_target_t;

  typedef logic [7:0] bdio_byte_t;

endpackage

// >>> src/bdio_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`include "bdio_map.svh"

module bdio_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin_raw,
  output logic      [W-1:0] pin_sync_q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] s1_d;
  logic [W-1:0] s2_d;
  logic [W-1:0] s3_d;
  logic [W-1:0] out_d;

  // ----------------------------------------------------------------------
  // Next state: a bit changes only once stages two and three agree
  // ----------------------------------------------------------------------
  always_comb begin
    s1_d  = pin_raw;
    s2_d  = s1_q;
    s3_d  = s2_q;
    out_d = pin_sync_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i]; // RULE_10
      end
    end
  end

  // Registers; s1 feeds only s2 to keep metastability contained
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q       <= W'(`BDIO_SYNC_RST);
      s2_q       <= W'(`BDIO_SYNC_RST);
      s3_q       <= W'(`BDIO_SYNC_RST);
      pin_sync_q <= W'(`BDIO_SYNC_RST);
    end else begin
      s1_q       <= s1_d;
      s2_q       <= s2_d;
      s3_q       <= s3_d;
      pin_sync_q <= out_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_sync_agree: assert property (@(posedge clk) disable iff (sys_rst) // RULE_10
    (s2_q == s3_q) |=> (pin_sync_q == $past(s3_q)))
    else $error("synchronised value does not follow agreeing stages");

endmodule

// >>> sim/bdio_pin_model.sv
// Model of the external circuits attached to one port's pins
`timescale 1ns/1ns

module bdio_pin_model #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] dev_out,
  input  wire logic [W-1:0] dev_oe,
  input  wire logic [W-1:0] dev_pu,
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  output logic      [W-1:0] pin
);
  logic [W-1:0] float_q = '0;

  // Lines neither driven nor pulled up wander every cycle so a stale level never reads as valid
  always @(posedge clk) begin
    float_q <= ~float_q;
  end

  // Wire resolution: both sides driving apart gives X, as real contention would
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (dev_oe[i] && ext_en[i] && (dev_out[i] != ext_val[i])) pin[i] = 1'bx;
      else if (dev_oe[i]) pin[i] = dev_out[i];
      else if (ext_en[i]) pin[i] = ext_val[i];
      else if (dev_pu[i]) pin[i] = 1'b1;
      else pin[i] = float_q[i];
    end
  end
endmodule

// >>> sim/test_bidirectional_io_ports.sv
// Self-checking bench for the bidirectional port block
`timescale 1ns/1ns

module test_bidirectional_io_ports;
  logic       clk       = 1'b0;
  logic       sys_rst   = 1'b1;
  logic [2:0] cpu_addr  = 3'h0;
  logic       cpu_wr    = 1'b0;
  logic       cpu_rd    = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata_q;
  logic       cpu_rvalid_q;
  logic [7:0] ext_val [3];
  logic [7:0] ext_en  [3];
  logic [7:0] pin     [3];
  logic [7:0] out_all [3];
  logic [7:0] oe_all  [3];
  logic [3:0] out3, oe3, pin3;
  logic [7:0] pu_one;
  logic [7:0] dir, lat, mask;
  int         num_errors = 0;
  int         n_tests    = 0;

  // ----------------------------------------------------------------------
  // Design, pin models and clock
  // ----------------------------------------------------------------------
  always #5 clk = ~clk;
  assign out_all[2] = {4'h0, out3};
  assign oe_all[2]  = {4'h0, oe3};
  assign pin[2]     = {4'h0, pin3};

  // Pull-up fitted so that its enable logic is exercised
  bdio_ports #(.PULLUP_EN(1'b1)) bdio_ports_i (.clk(clk), .sys_rst(sys_rst),
    .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q),
    .cpu_rvalid_q(cpu_rvalid_q), .port_one_lines_in(pin[0]),
    .port_one_lines_out_q(out_all[0]), .port_one_lines_oe_q(oe_all[0]),
    .port_one_pullup_q(pu_one), .port_two_lines_in(pin[1]),
    .port_two_lines_out_q(out_all[1]), .port_two_lines_oe_q(oe_all[1]),
    .port_three_lines_in(pin3), .port_three_lines_out_q(out3),
    .port_three_lines_oe_q(oe3));
  bdio_pin_model #(.W(8)) pins_one_i (.clk(clk), .dev_out(out_all[0]), .dev_oe(oe_all[0]),
    .dev_pu(pu_one), .ext_val(ext_val[0]), .ext_en(ext_en[0]), .pin(pin[0]));
  bdio_pin_model #(.W(8)) pins_two_i (.clk(clk), .dev_out(out_all[1]), .dev_oe(oe_all[1]),
    .dev_pu(8'h00), .ext_val(ext_val[1]), .ext_en(ext_en[1]), .pin(pin[1]));
  bdio_pin_model #(.W(4)) pins_three_i (.clk(clk), .dev_out(out3), .dev_oe(oe3),
    .dev_pu(4'h0), .ext_val(ext_val[2][3:0]), .ext_en(ext_en[2][3:0]), .pin(pin3));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Output lines show the latch, input lines the pin
  function automatic logic [7:0] exp_read(logic [7:0] d, logic [7:0] l, logic [7:0] p,
                                          logic [7:0] m);
    return ((d & l) | (~d & p)) & m;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    cpu_wr    <= 1'b1;
    cpu_addr  <= a;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_wr <= 1'b0;
  endtask

  // Read data is checked in the single cycle that cpu_rvalid_q is high
  task automatic bus_rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    cpu_rd   <= 1'b1;
    cpu_addr <= a;
    @(posedge clk);
    cpu_rd <= 1'b0;
    #1;
    check({7'h00, cpu_rvalid_q}, 8'h01);
    check(cpu_rdata_q, exp);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    for (int p = 0; p < 3; p++) begin
      ext_val[p] = 8'h00;
      ext_en[p]  = 8'h00;
    end
    void'($urandom(65956));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    for (int p = 0; p < 3; p++) check(oe_all[p], 8'h00);
    check(pu_one, 8'hFF);
    for (int a = 3; a < 8; a++) bus_rd(3'(a), (a == 3 || a == 7) ? 8'h00 : 8'hFF);
    $display("test reset and read-back done");
    // All-input, all-output, then random directions on every port
    for (int i = 0; i < 24; i++) begin
      int p;
      p    = i % 3;
      mask = (p == 2) ? 8'h0F : 8'hFF;
      dir  = (i < 3) ? 8'h00 : (i < 6) ? 8'hFF : 8'($urandom);
      lat  = 8'($urandom);
      bus_wr(3'(p), lat);
      @(posedge clk);
      ext_en[p] <= 8'h00;
      bus_wr(3'(p + 4), dir);
      @(posedge clk);
      ext_en[p]  <= ~dir;
      ext_val[p] <= 8'($urandom);
      repeat (4) @(posedge clk);
      #1;
      check(out_all[p], lat & mask);
      check(oe_all[p], dir & mask);
      if (p == 0) check(pu_one, ~dir);
      bus_rd(3'(p), exp_read(dir, lat, ext_val[p], mask));
    end
    $display("test direction and data done");
    // A pin change is not visible to a read two edges later
    bus_wr(3'h4, 8'h00);
    @(posedge clk);
    ext_en[0]  <= 8'hFF;
    ext_val[0] <= 8'h00;
    repeat (4) @(posedge clk);
    ext_val[0] <= 8'hFF;
    bus_rd(3'h0, 8'h00);
    repeat (4) @(posedge clk);
    bus_rd(3'h0, 8'hFF);
    $display("test pin synchroniser done");
    // Reset in mid-run keeps latches and ignores writes; far side lets go first
    @(posedge clk);
    ext_en[1] <= 8'h00;
    bus_wr(3'h5, 8'hFF);
    @(posedge clk);
    sys_rst <= 1'b1;
    lat = out_all[1];
    bus_wr(3'h1, ~lat);
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check(out_all[1], lat);
    check(oe_all[1], 8'h00);
    check(pu_one, 8'hFF);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule
